// File: epm_pkg.sv
// Purpose: shared constants and types for the ethernet port pin multiplexer
// Assumes: eight access ports and one uplink port
// Notes: select encodings follow the per-port interface-select field
package epm_pkg;
   localparam int EPM_NUM_ACCESS = 8;
   localparam int EPM_SEL_HI = 4;
   localparam int EPM_SEL_LO = 3;
   localparam logic [1:0] EPM_ACC_RMII = 2'h3;
   localparam logic [1:0] EPM_ACC_MII = 2'h1;
   localparam logic [1:0] EPM_ACC_GSI = 2'h0;
   localparam logic [1:0] EPM_UP_GMII = 2'h3;
   localparam logic [1:0] EPM_UP_MII = 2'h0;
   localparam logic [4:0] EPM_CFG_RESET = 5'h18;
   localparam logic [3:0] EPM_QUIET_CYCLES = 4'h4;
   localparam logic [1:0] EPM_PRESENT_SYNC = 2'h2;

   typedef enum logic [2:0] {
      EPM_NONE = 3'h1,
      EPM_SETTLE = 3'h2,
      EPM_LIVE = 3'h4
   } epm_state_t;

   // pad control per access port: pull enables and output enables
   typedef struct packed {
      logic [3:0] rxd_pu;
      logic crs_pu;
      logic col_pd;
      logic txclk_pu;
      logic rxclk_pu;
      logic [3:0] txd_oe;
      logic txen_oe;
      logic clk_oe;
      logic traffic_ok;
   } epm_acc_pad_t;

   typedef struct packed {
      logic [7:0] rxd_pu;
      logic rxdv_pu;
      logic rxer_pu;
      logic crs_pd;
      logic col_pd;
      logic rxclk_pu;
      logic refclk_pu;
      logic mtxclk_pu;
      logic txen_pu;
      logic txer_pu;
      logic [7:0] txd_oe;
      logic txen_oe;
      logic txer_oe;
      logic txclk_oe;
      logic rxclk_oe;
      logic traffic_ok;
   } epm_up_pad_t;
endpackage : epm_pkg

// File: epm_ethernet_port_iface_mux.sv
// Purpose: per-port pin direction and pull control for the switch ethernet ports
// Assumes: link presence sense comes from a pin on the link clock domain
// Notes: traffic is held off until pads have settled after any select change
`timescale 1ns/1ps
`default_nettype none
module epm_ethernet_port_iface_mux
   import epm_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic LINK_CLK,
   input wire logic MODULE_DETECT_STRAP,
   input wire logic [EPM_NUM_ACCESS-1:0] PHY_PRESENT,
   input wire logic UPLINK_PHY_PRESENT,
   input wire logic [EPM_NUM_ACCESS*5-1:0] ACCESS_PORT_IFACE_SELECT,
   input wire logic [4:0] UPLINK_IFACE_SELECT,
   output var epm_acc_pad_t [EPM_NUM_ACCESS-1:0] ACCESS_PAD,
   output var epm_up_pad_t UPLINK_PAD,
   output logic MODULE_WATCH
);
   // ==========================================================
   // presence sampling on the link clock, then crossing
   logic [EPM_NUM_ACCESS:0] pres_link;
   logic [EPM_NUM_ACCESS:0] pres_s1;
   logic [EPM_NUM_ACCESS:0] pres_s2;
   logic [1:0] rst_link;
   logic strap_s1;
   logic strap_s2;
   logic strap_taken;

   // the link side gets its own synchronised reset release
   always_ff @(posedge LINK_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_link <= 2'h0;
      end else begin
         rst_link <= {rst_link[0], 1'b1};
      end
   end

   always_ff @(posedge LINK_CLK or negedge RST_B) begin
      if (!RST_B) begin
         pres_link <= '0;
      end else begin
         pres_link <= rst_link[1] ? {UPLINK_PHY_PRESENT, PHY_PRESENT} : '0;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         pres_s1 <= '0;
         pres_s2 <= '0;
      end else begin
         pres_s1 <= pres_link;
         pres_s2 <= pres_s1;
      end
   end

   // ==========================================================
   // strap capture after reset release
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         strap_s1 <= 1'b0;
         strap_s2 <= 1'b0;
      end else begin
         strap_s1 <= MODULE_DETECT_STRAP;
         strap_s2 <= strap_s1;
      end
   end

   logic [EPM_PRESENT_SYNC:0] cap_cnt;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cap_cnt <= '0;
         strap_taken <= 1'b0;
         MODULE_WATCH <= 1'b0;
      end else if (!strap_taken) begin
         cap_cnt <= cap_cnt + 3'h1;
         if (cap_cnt == 3'(EPM_PRESENT_SYNC)) begin
            strap_taken <= 1'b1;
            MODULE_WATCH <= strap_s2;
         end
      end
   end

   // a port counts as empty only while the watch is on and no PHY is sensed
   function automatic logic empty_port(input logic watch, input logic present);
      empty_port = watch & ~present;
   endfunction : empty_port

   // ==========================================================
   // access ports
   for (genvar p = 0; p < EPM_NUM_ACCESS; p++) begin : g_acc
      logic [1:0] sel;
      logic [1:0] sel_seen;
      logic empty_seen;
      logic empty;
      logic [3:0] quiet;
      epm_state_t state;
      epm_acc_pad_t next_pad;

      assign sel = ACCESS_PORT_IFACE_SELECT[p*5+EPM_SEL_HI -: 2];
      assign empty = empty_port(MODULE_WATCH, pres_s2[p]);

      always_comb begin
         next_pad = '0;
         next_pad.txd_oe = 4'hf;  // transmit stays driven in all modes
         next_pad.txen_oe = 1'b1;
         next_pad.crs_pu = 1'b0;
         if (empty) begin
            next_pad.rxd_pu = 4'hf;
            next_pad.crs_pu = 1'b1;
            next_pad.col_pd = 1'b1;
            next_pad.txclk_pu = 1'b1;
            next_pad.rxclk_pu = 1'b1;
         end else begin
            unique case (sel)
               EPM_ACC_RMII: begin
                  next_pad.rxd_pu = 4'hc;
                  next_pad.col_pd = 1'b1;
                  next_pad.txclk_pu = 1'b1;
                  next_pad.rxclk_pu = 1'b1;
               end
               EPM_ACC_MII: begin
                  next_pad.clk_oe = 1'b1;
               end
               EPM_ACC_GSI: begin
                  next_pad.rxd_pu = 4'he;
                  next_pad.clk_oe = 1'b1;
               end
               default: begin
                  // undefined code: pads held safe, as if empty
                  next_pad.rxd_pu = 4'hf;
                  next_pad.crs_pu = 1'b1;
                  next_pad.col_pd = 1'b1;
                  next_pad.txclk_pu = 1'b1;
                  next_pad.rxclk_pu = 1'b1;
               end
            endcase
         end
         // a change seen this cycle drops traffic in the same update as the new pads
         next_pad.traffic_ok = (state == EPM_LIVE) && !empty && sel == sel_seen
            && empty == empty_seen;
      end

      // pads update at once; traffic waits out a quiet period
      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            state <= EPM_SETTLE;
            quiet <= '0;
            sel_seen <= EPM_CFG_RESET[EPM_SEL_HI:EPM_SEL_LO];
            empty_seen <= 1'b0;
         end else begin
            sel_seen <= sel;
            empty_seen <= empty;
            unique case (state)
               EPM_NONE, EPM_SETTLE: begin
                  quiet <= quiet + 4'h1;
                  if (quiet == EPM_QUIET_CYCLES) begin
                     state <= EPM_LIVE;
                  end
               end
               EPM_LIVE: begin
                  quiet <= '0;
               end
               default: state <= EPM_SETTLE;
            endcase
            if (sel != sel_seen || empty != empty_seen) begin
               state <= empty ? EPM_NONE : EPM_SETTLE;
               quiet <= '0;
            end
         end
      end

      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            ACCESS_PAD[p] <= '0;
         end else begin
            ACCESS_PAD[p] <= next_pad;
         end
      end
   end

   // ==========================================================
   // uplink port
   logic [1:0] up_sel;
   logic [1:0] up_sel_seen;
   logic up_empty;
   logic up_empty_seen;
   logic [3:0] up_quiet;
   logic up_live;
   epm_up_pad_t next_up;

   assign up_sel = UPLINK_IFACE_SELECT[EPM_SEL_HI:EPM_SEL_LO];
   assign up_empty = empty_port(MODULE_WATCH, pres_s2[EPM_NUM_ACCESS]);

   always_comb begin
      next_up = '0;
      next_up.txd_oe = 8'hff;
      if (up_empty) begin
         next_up.rxd_pu = 8'hff;
         next_up.rxdv_pu = 1'b1;
         next_up.rxer_pu = 1'b1;
         next_up.crs_pd = 1'b1;
         next_up.col_pd = 1'b1;
         next_up.rxclk_pu = 1'b1;
         next_up.refclk_pu = 1'b1;
         next_up.mtxclk_pu = 1'b1;
         next_up.txen_pu = 1'b1;
         next_up.txer_pu = 1'b1;
         next_up.txd_oe = 8'hff;
         next_up.txclk_oe = 1'b1;
      end else begin
         unique case (up_sel)
            EPM_UP_GMII: begin
               next_up.txd_oe = 8'hff;
               next_up.txen_oe = 1'b1;
               next_up.txer_oe = 1'b1;
               next_up.txclk_oe = 1'b1;
            end
            EPM_UP_MII: begin
               next_up.rxd_pu = 8'hf0;
               next_up.rxer_pu = 1'b1;
               next_up.txd_oe = 8'hff;
               next_up.txen_oe = 1'b1;
               next_up.txer_oe = 1'b1;
               next_up.txclk_oe = 1'b1;
               next_up.rxclk_oe = 1'b1;
            end
            default: begin
               // undefined code: pads held safe, as if no module were fitted
               next_up.rxd_pu = 8'hff;
               next_up.rxdv_pu = 1'b1;
               next_up.rxer_pu = 1'b1;
               next_up.crs_pd = 1'b1;
               next_up.col_pd = 1'b1;
               next_up.rxclk_pu = 1'b1;
               next_up.refclk_pu = 1'b1;
               next_up.mtxclk_pu = 1'b1;
               next_up.txen_pu = 1'b1;
               next_up.txer_pu = 1'b1;
               next_up.txclk_oe = 1'b1;
            end
         endcase
      end
      next_up.traffic_ok = up_live && !up_empty && up_sel == up_sel_seen
         && up_empty == up_empty_seen;
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         up_live <= 1'b0;
         up_quiet <= '0;
         up_sel_seen <= EPM_CFG_RESET[EPM_SEL_HI:EPM_SEL_LO];
         up_empty_seen <= 1'b0;
         UPLINK_PAD <= '0;
      end else begin
         up_sel_seen <= up_sel;
         up_empty_seen <= up_empty;
         UPLINK_PAD <= next_up;
         if (up_sel != up_sel_seen || up_empty != up_empty_seen) begin
            up_live <= 1'b0;
            up_quiet <= '0;
         end else if (!up_live) begin
            up_quiet <= up_quiet + 4'h1;
            up_live <= (up_quiet == EPM_QUIET_CYCLES);
         end
      end
   end
endmodule : epm_ethernet_port_iface_mux
`default_nettype wire

// File: epm_phy_model.sv
// Purpose: presence sense of the module or PHY on each port
// Assumes: presence is a level seen on the link clock
// Notes: plug changes land only after a link clock edge
`timescale 1ns/1ps
`default_nettype none
module epm_phy_model (
   input wire logic LINK_CLK,
   input wire logic [8:0] plug,
   output logic [7:0] phy_present,
   output logic uplink_phy_present
);
   // ==========
   // sense lines
   // a real sense line moves on its own clock, never in step with the switch clock
   initial {uplink_phy_present, phy_present} = 9'h000;
   always @(posedge LINK_CLK) begin
      {uplink_phy_present, phy_present} <= #1 plug;
   end
endmodule : epm_phy_model
`default_nettype wire

// File: epm_ethernet_port_iface_mux_chk.sv
// Purpose: pad relation checks for the port pin mux
// Assumes: only the system clock domain is watched
// Notes: pads are judged one edge after the select is taken
`timescale 1ns/1ps
`default_nettype none
module epm_ethernet_port_iface_mux_chk
   import epm_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic MODULE_DETECT_STRAP,
   input wire logic [EPM_NUM_ACCESS-1:0] PHY_PRESENT,
   input wire logic [EPM_NUM_ACCESS*5-1:0] ACCESS_PORT_IFACE_SELECT,
   input wire logic [4:0] UPLINK_IFACE_SELECT,
   input wire epm_acc_pad_t [EPM_NUM_ACCESS-1:0] ACCESS_PAD,
   input wire epm_up_pad_t UPLINK_PAD,
   input wire logic MODULE_WATCH
);
   // ==========
   // cycles since reset
   logic [2:0] cnt;
   wire logic live = cnt != 3'h0 && !MODULE_WATCH;
   wire logic [1:0] sa = ACCESS_PORT_IFACE_SELECT[4:3];
   wire logic [1:0] su = UPLINK_IFACE_SELECT[4:3];
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cnt <= 3'h0;
      end else if (cnt != 3'h7) begin
         cnt <= cnt + 3'h1;
      end
   end
   // ==========
   // pad relations
   acc_rmii_a: assert property (live && $past(sa) == EPM_ACC_RMII |->
      ACCESS_PAD[0].rxd_pu == 4'hc && ACCESS_PAD[0].col_pd) else $error("rmii pulls");
   acc_mii_a: assert property (live && $past(sa) == EPM_ACC_MII |->
      ACCESS_PAD[0].rxd_pu == 4'h0 && !ACCESS_PAD[0].col_pd) else $error("mii pulls");
   acc_gsi_a: assert property (live && $past(sa) == EPM_ACC_GSI |->
      ACCESS_PAD[0].rxd_pu == 4'he && !ACCESS_PAD[0].crs_pu) else $error("serial pulls");
   up_gmii_a: assert property (live && $past(su) == EPM_UP_GMII |->
      UPLINK_PAD.rxd_pu == 8'h00 && UPLINK_PAD.txer_oe) else $error("gmii pads");
   up_mii_a: assert property (live && $past(su) == EPM_UP_MII |->
      UPLINK_PAD.rxd_pu == 8'hf0 && UPLINK_PAD.rxer_pu) else $error("uplink mii pads");
   settle_hold_a: assert property (cnt > 3'h1 && $changed(sa) |->
      ##1 !ACCESS_PAD[0].traffic_ok) else $error("traffic before settle");
   empty_port_a: assert property (MODULE_WATCH && $past(MODULE_WATCH) &&
      !PHY_PRESENT[1] && !$past(PHY_PRESENT[1], 8) |-> ACCESS_PAD[1].rxd_pu == 4'hf
      && ACCESS_PAD[1].col_pd && !ACCESS_PAD[1].traffic_ok) else $error("empty port pads");
   watch_strap_a: assert property (cnt == 3'h7 |->
      MODULE_WATCH == MODULE_DETECT_STRAP) else $error("watch not from strap");
endmodule : epm_ethernet_port_iface_mux_chk
bind epm_ethernet_port_iface_mux epm_ethernet_port_iface_mux_chk chk (.CLK, .RST_B,
   .MODULE_DETECT_STRAP, .PHY_PRESENT, .ACCESS_PORT_IFACE_SELECT, .UPLINK_IFACE_SELECT,
   .ACCESS_PAD, .UPLINK_PAD, .MODULE_WATCH);
`default_nettype wire

// File: epm_ethernet_port_iface_mux_tb_top.sv
// Purpose: self-checking bench for the port pin mux
// Assumes: pads settle within 12 cycles of a select change
// Notes: two-way clock pins are expected driven only in the modes that use them
`timescale 1ns/1ps
`default_nettype none
module epm_ethernet_port_iface_mux_tb_top
   import epm_pkg::*;
;
   logic CLK = 1'b0;
   logic LINK_CLK = 1'b0;
   logic RST_B = 1'b0;
   logic strap = 1'b0;
   logic [8:0] plug = 9'h1ff;
   logic [39:0] acc_sel = {8{EPM_CFG_RESET}};
   logic [4:0] up_sel = EPM_CFG_RESET;
   logic [1:0] codes [3] = '{EPM_ACC_RMII, EPM_ACC_MII, EPM_ACC_GSI};
   wire logic [7:0] present;
   wire logic up_present;
   epm_acc_pad_t [7:0] acc_pad;
   epm_up_pad_t up_pad;
   logic watch;
   int error_cnt = 0;
   int tests_run = 0;
   int seed = 57288;
   int i;
   int p;
   epm_ethernet_port_iface_mux DUT (.CLK(CLK), .RST_B(RST_B), .LINK_CLK(LINK_CLK),
      .MODULE_DETECT_STRAP(strap), .PHY_PRESENT(present), .UPLINK_PHY_PRESENT(up_present),
      .ACCESS_PORT_IFACE_SELECT(acc_sel), .UPLINK_IFACE_SELECT(up_sel),
      .ACCESS_PAD(acc_pad), .UPLINK_PAD(up_pad), .MODULE_WATCH(watch));
   epm_phy_model phy (.LINK_CLK(LINK_CLK), .plug(plug), .phy_present(present),
      .uplink_phy_present(up_present));
   initial begin
      forever #5 CLK = ~CLK;
   end
   initial begin
      #3.3;
      forever #7.5 LINK_CLK = ~LINK_CLK;
   end
   // ==========
   // reference pads
   // an undefined select code is expected to look like an empty port, traffic aside
   function automatic epm_acc_pad_t acc_exp(input logic [1:0] s, input logic e);
      epm_acc_pad_t x;
      logic z;
      x = '0;
      z = e || !(s inside {EPM_ACC_RMII, EPM_ACC_MII, EPM_ACC_GSI});
      {x.txd_oe, x.txen_oe} = 5'h1f;
      x.col_pd = z || s == EPM_ACC_RMII;
      {x.txclk_pu, x.rxclk_pu} = {2{x.col_pd}};
      x.crs_pu = z;
      x.rxd_pu = z ? 4'hf : s == EPM_ACC_RMII ? 4'hc : s == EPM_ACC_GSI ? 4'he : 4'h0;
      x.clk_oe = !z && s != EPM_ACC_RMII;
      x.traffic_ok = !e;
      return x;
   endfunction : acc_exp
   function automatic epm_up_pad_t up_exp(input logic [1:0] s, input logic e);
      epm_up_pad_t x;
      logic z;
      x = '0;
      z = e || !(s inside {EPM_UP_GMII, EPM_UP_MII});
      {x.txd_oe, x.txclk_oe} = 9'h1ff;
      {x.txen_oe, x.txer_oe} = {2{!z}};
      x.rxd_pu = z ? 8'hff : s == EPM_UP_MII ? 8'hf0 : 8'h00;
      x.rxer_pu = z || s == EPM_UP_MII;
      x.rxclk_oe = !z && s == EPM_UP_MII;
      {x.rxdv_pu, x.crs_pd, x.col_pd, x.rxclk_pu} = {4{z}};
      {x.refclk_pu, x.mtxclk_pu, x.txen_pu, x.txer_pu} = {4{z}};
      x.traffic_ok = !e;
      return x;
   endfunction : up_exp
   // ==========
   // compare and close
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic check_all(input logic [7:0] ea, input logic eu);
      epm_acc_pad_t a;
      epm_up_pad_t u;
      for (p = 0; p < 8; p++) begin
         a = acc_pad[p];
         chk(a, acc_exp(acc_sel[p*5+3 +: 2], ea[p]));
      end
      u = up_pad;
      chk(u, up_exp(up_sel[4:3], eu));
   endtask : check_all
   task automatic close_out;
      $display("mismatches %0d of %0d checks", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out
   // ==========
   // scenarios
   initial begin
      repeat (3) @(posedge CLK);
      #1 RST_B = 1'b1;
      for (i = 0; i < 6; i++) begin
         repeat (2) @(posedge CLK);
         #1;
         for (p = 0; p < 8; p++) begin
            acc_sel[p*5 +: 5] = {codes[$unsigned($random(seed)) % 3], 3'($random(seed))};
         end
         acc_sel[4:3] = codes[i % 3];
         up_sel = {i[0] ? EPM_UP_GMII : EPM_UP_MII, 3'($random(seed))};
         repeat (2) @(posedge CLK);
         #1 chk(acc_pad[0].traffic_ok, 1'b0);
         chk(watch, 1'b0);
         repeat (12) @(posedge CLK);
         #1 check_all(8'h00, 1'b0);
      end
      // undefined select codes on every port
      acc_sel = {8{5'h10}};
      up_sel = 5'h08;
      repeat (14) @(posedge CLK);
      #1 check_all(8'h00, 1'b0);
      up_sel = {EPM_UP_GMII, 3'h0};
      // second reset with module watch on and port 1 empty
      RST_B = 1'b0;
      strap = 1'b1;
      plug = 9'h1fd;
      repeat (3) @(posedge CLK);
      #1 RST_B = 1'b1;
      repeat (14) @(posedge CLK);
      #1 chk(watch, 1'b1);
      check_all(8'h02, 1'b0);
      plug = 9'h0ff;
      repeat (14) @(posedge CLK);
      #1 check_all(8'h00, 1'b1);
      close_out();
   end
endmodule : epm_ethernet_port_iface_mux_tb_top
`default_nettype wire
